//--- shared/pifb_pkg.sv
package pifb_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_FLAGS_A = 4'h0;
   localparam logic [3:0] OFS_FLAGS_B = 4'h1;
   localparam logic [3:0] OFS_FLAGS_C = 4'h2;
   localparam logic [3:0] OFS_EN_A = 4'h4;
   localparam logic [3:0] OFS_EN_B = 4'h5;
   localparam logic [3:0] OFS_EN_C = 4'h6;
   localparam logic [3:0] OFS_CORE_CTL = 4'h8;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h9;
   localparam logic [3:0] OFS_IRQ_MASK = 4'ha;

   // Reset values
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_EN = 8'h00;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_STAT = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;

   // Software-writable bits of each flag register
   localparam logic [7:0] WMASK_A = 8'hcf;
   localparam logic [7:0] WMASK_B = 8'hef;
   localparam logic [7:0] WMASK_C = 8'hff;
   // Implemented bits (unimplemented read as zero)
   localparam logic [7:0] IMPL_B = 8'hef;

   // Flag register A fields
   localparam int A_T1_GATE = 7;
   localparam int A_ADC_DONE = 6;
   localparam int A_UART_A_RX = 5;
   localparam int A_UART_A_TX = 4;
   localparam int A_SYNC_SER_A = 3;
   localparam int A_CAPCMP_A = 2;
   localparam int A_T2_MATCH = 1;
   localparam int A_T1_OVF = 0;
   // Flag register B fields
   localparam int B_OSC_FAIL = 7;
   localparam int B_T5_GATE = 6;
   localparam int B_T3_GATE = 5;
   localparam int B_SS_A_COLL = 3;
   localparam int B_T10_MATCH = 2;
   localparam int B_T8_MATCH = 1;
   localparam int B_CAPCMP_B = 0;
   // Flag register C fields
   localparam int C_CAPCMP_F = 7;
   localparam int C_CAPCMP_E = 6;
   localparam int C_CAPCMP_D = 5;
   localparam int C_CAPCMP_C = 4;
   localparam int C_T6_MATCH = 3;
   localparam int C_T5_OVF = 2;
   localparam int C_T4_MATCH = 1;
   localparam int C_T3_OVF = 0;

   // Core control fields
   localparam int CTL_GLOBAL_EN = 7;
   localparam int CTL_PERIPH_EN = 6;

   // Interrupt status fields
   localparam int ST_FLAG_A = 0;
   localparam int ST_FLAG_B = 1;
   localparam int ST_FLAG_C = 2;
   localparam int ST_REQ = 3;

   typedef struct packed {
      logic t1_gate_flag;
      logic adc_done_flag;
      logic uart_a_rx_flag;
      logic uart_a_tx_flag;
      logic sync_serial_a_flag;
      logic capcmp_a_flag;
      logic t2_period_match_flag;
      logic t1_overflow_flag;
   } pifb_src_a_s;

   typedef struct packed {
      logic osc_fail_flag;
      logic t5_gate_flag;
      logic t3_gate_flag;
      logic unused_flag;
      logic sync_serial_a_collision_flag;
      logic t10_period_match_flag;
      logic t8_period_match_flag;
      logic capcmp_b_flag;
   } pifb_src_b_s;

   typedef struct packed {
      logic capcmp_f_flag;
      logic capcmp_e_flag;
      logic capcmp_d_flag;
      logic capcmp_c_flag;
      logic t6_period_match_flag;
      logic t5_overflow_flag;
      logic t4_period_match_flag;
      logic t3_overflow_flag;
   } pifb_src_c_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pifb_bus_s;

endpackage

//--- design/pifb_flag_bank.sv
`timescale 1ns/1ps
module pifb_flag_bank #(
   parameter int NUM_REGS = 3
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire pifb_pkg::pifb_bus_s bus,
   output logic [7:0] rdata,
   input wire pifb_pkg::pifb_src_a_s src_a,
   input wire pifb_pkg::pifb_src_b_s src_b,
   input wire pifb_pkg::pifb_src_c_s src_c,
   output logic periph_irq_req,
   output logic irq
);

   logic [7:0] flags_q [NUM_REGS];
   logic [7:0] en_q [NUM_REGS];
   logic [7:0] set_vec [NUM_REGS];
   logic [7:0] wmask [NUM_REGS];
   logic [7:0] impl [NUM_REGS];
   logic [NUM_REGS-1:0] pend;
   logic [7:0] ctl_q;
   logic [7:0] stat_q;
   logic [7:0] mask_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_d;
   logic [7:0] ev_d;
   logic req_prev_q;
   logic req_d;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      return a == ofs;
   endfunction

   assign set_vec[0] = src_a;
   // source bit placement, bit 4 dropped
   assign set_vec[1] = src_b & pifb_pkg::IMPL_B;
   assign set_vec[2] = src_c;
   assign wmask[0] = pifb_pkg::WMASK_A;
   assign wmask[1] = pifb_pkg::WMASK_B;
   assign wmask[2] = pifb_pkg::WMASK_C;
   assign impl[0] = 8'hff;
   assign impl[1] = pifb_pkg::IMPL_B;
   assign impl[2] = 8'hff;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         logic wr_flag;
         logic wr_en;
         assign wr_flag = bus.wr &&
            hit(bus.addr, pifb_pkg::OFS_FLAGS_A + 4'(gi));
         assign wr_en = bus.wr &&
            hit(bus.addr, pifb_pkg::OFS_EN_A + 4'(gi));

         always_ff @(posedge clock) begin
            if (srst) begin
               flags_q[gi] <= pifb_pkg::RST_FLAGS;
            end else if (clk_en) begin
               // set independent of enables, set wins
               if (wr_flag) begin
                  flags_q[gi] <= ((bus.wdata & wmask[gi]) |
                     (flags_q[gi] & ~wmask[gi]) | set_vec[gi]) & impl[gi];
               end else begin
                  flags_q[gi] <= flags_q[gi] | set_vec[gi];
               end
            end
         end

         always_ff @(posedge clock) begin
            if (srst) begin
               en_q[gi] <= pifb_pkg::RST_EN;
            end else if (clk_en && wr_en) begin
               en_q[gi] <= bus.wdata & impl[gi];
            end
         end

         assign pend[gi] = |(flags_q[gi] & en_q[gi]);
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (srst) begin
         ctl_q <= pifb_pkg::RST_CTL;
      end else if (clk_en && bus.wr &&
                   hit(bus.addr, pifb_pkg::OFS_CORE_CTL)) begin
         ctl_q <= bus.wdata & 8'hc0;
      end
   end

   assign req_d = (|pend) && ctl_q[pifb_pkg::CTL_PERIPH_EN] &&
      ctl_q[pifb_pkg::CTL_GLOBAL_EN];
   assign periph_irq_req = req_d;

   always_ff @(posedge clock) begin
      if (srst) begin
         req_prev_q <= 1'b0;
      end else if (clk_en) begin
         req_prev_q <= req_d;
      end
   end

   // Events: a register gaining a newly set flag, enabled or not, and request rising
   always_comb begin
      ev_d = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         ev_d[i] = |(set_vec[i] & ~flags_q[i]);
      end
      ev_d[pifb_pkg::ST_REQ] = req_d && !req_prev_q;
   end

   // Read clears status, but a new event in that cycle still lands
   always_ff @(posedge clock) begin
      if (srst) begin
         stat_q <= pifb_pkg::RST_STAT;
      end else if (clk_en) begin
         if (bus.rd && hit(bus.addr, pifb_pkg::OFS_IRQ_STAT)) begin
            stat_q <= ev_d;
         end else begin
            stat_q <= stat_q | ev_d;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mask_q <= pifb_pkg::RST_MASK;
      end else if (clk_en && bus.wr &&
                   hit(bus.addr, pifb_pkg::OFS_IRQ_MASK)) begin
         mask_q <= bus.wdata & 8'h0f;
      end
   end

   assign irq = |(stat_q & mask_q);

   always_comb begin
      rd_d = 8'h00;
      case (bus.addr)
         pifb_pkg::OFS_FLAGS_A: rd_d = flags_q[0];
         pifb_pkg::OFS_FLAGS_B: rd_d = flags_q[1] & pifb_pkg::IMPL_B;
         pifb_pkg::OFS_FLAGS_C: rd_d = flags_q[2];
         pifb_pkg::OFS_EN_A: rd_d = en_q[0];
         pifb_pkg::OFS_EN_B: rd_d = en_q[1];
         pifb_pkg::OFS_EN_C: rd_d = en_q[2];
         pifb_pkg::OFS_CORE_CTL: rd_d = ctl_q;
         pifb_pkg::OFS_IRQ_STAT: rd_d = stat_q;
         pifb_pkg::OFS_IRQ_MASK: rd_d = mask_q;
         default: rd_d = 8'h00;
      endcase
   end

   // Data is valid only in the cycle after the read strobe
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         rdata_q <= bus.rd ? rd_d : 8'h00;
      end
   end

   assign rdata = rdata_q;

endmodule

//--- dv/pifb_flag_bank_properties.sv
`timescale 1ns/1ps
module pifb_flag_bank_properties (
   input wire logic clock,
   input wire logic srst,
   input wire logic clk_en,
   input wire pifb_pkg::pifb_bus_s bus,
   input wire logic [7:0] rdata,
   input wire pifb_pkg::pifb_src_a_s src_a,
   input wire pifb_pkg::pifb_src_b_s src_b,
   input wire pifb_pkg::pifb_src_c_s src_c,
   input wire logic periph_irq_req,
   input wire logic irq
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   wire rd_a = clk_en && bus.rd && bus.addr == pifb_pkg::OFS_FLAGS_A;
   wire rd_c = clk_en && bus.rd && bus.addr == pifb_pkg::OFS_FLAGS_C;
   wire any_src = (src_a | src_b | src_c) != 8'h00;
   idle_rd_zero_a: assert property (
      clk_en && !bus.rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   rst_clear_a: assert property (
      disable iff (1'b0) srst |=> rdata == 8'h00 && !irq && !periph_irq_req)
      else $error("outputs not cleared by reset");
   unimpl_zero_a: assert property (
      clk_en && bus.rd && bus.addr == pifb_pkg::OFS_FLAGS_B |=> !rdata[4])
      else $error("unimplemented flag reads one");
   // Events are sampled one cycle before the read, so they must show
   flag_a_set_a: assert property (
      rd_a && $past(clk_en) && !$past(srst)
      |=> (rdata & $past(src_a, 2)) == $past(src_a, 2))
      else $error("event missing from first flag register");
   flag_c_set_a: assert property (
      rd_c && $past(clk_en) && !$past(srst)
      |=> (rdata & $past(src_c, 2)) == $past(src_c, 2))
      else $error("event missing from third flag register");
   req_rise_a: assert property (
      $rose(periph_irq_req) && !$past(srst)
      |-> $past(clk_en && (bus.wr || any_src)))
      else $error("request rose without event or write");
   req_fall_a: assert property (
      $fell(periph_irq_req) && !$past(srst) |-> $past(clk_en && bus.wr))
      else $error("request fell without a write");
   irq_fall_a: assert property (
      $fell(irq) && !$past(srst) |-> $past(clk_en && (bus.rd || bus.wr)))
      else $error("interrupt fell without bus access");
   cover property (rd_a ##1 rdata != 8'h00);
   cover property ($rose(irq));
   cover property ($fell(periph_irq_req));
endmodule
bind pifb_flag_bank pifb_flag_bank_properties pifb_flag_bank_properties_inst (
   .clock(clock), .srst(srst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
   .src_a(src_a), .src_b(src_b), .src_c(src_c),
   .periph_irq_req(periph_irq_req), .irq(irq));

//--- dv/pifb_periph_model.sv
`timescale 1ns/1ps
// Peripherals pulse their events for one cycle and stay quiet otherwise
module pifb_periph_model (
   input wire logic clock,
   input wire logic fire,
   input wire logic [23:0] pattern,
   output pifb_pkg::pifb_src_a_s src_a,
   output pifb_pkg::pifb_src_b_s src_b,
   output pifb_pkg::pifb_src_c_s src_c
);
   initial {src_a, src_b, src_c} = 24'h000000;
   always @(posedge clock) begin
      {src_a, src_b, src_c} <= fire ? pattern : 24'h000000;
   end
endmodule

//--- dv/pifb_flag_bank_bench.sv
`timescale 1ns/1ps
module pifb_flag_bank_bench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic clk_en = 1'b1;
   logic fire = 1'b0;
   logic [23:0] ev = 24'h000000;
   pifb_pkg::pifb_bus_s bus = '0;
   pifb_pkg::pifb_src_a_s src_a;
   pifb_pkg::pifb_src_b_s src_b;
   pifb_pkg::pifb_src_c_s src_c;
   logic [7:0] rdata, d;
   logic [3:0] a;
   logic [23:0] p;
   logic periph_irq_req, irq;
   logic [31:0] lf = 32'hf3921318;
   int err_total = 0;
   int checks_done = 0;
   int fm[3] = '{0, 0, 0};
   int wm[3] = '{pifb_pkg::WMASK_A, pifb_pkg::WMASK_B, pifb_pkg::WMASK_C};
   always #2 clock = ~clock;
   pifb_periph_model pifb_periph_model_inst (.clock(clock), .fire(fire),
      .pattern(ev), .src_a(src_a), .src_b(src_b), .src_c(src_c));
   pifb_flag_bank pifb_flag_bank_inst (.clock(clock), .srst(srst),
      .clk_en(clk_en), .bus(bus), .rdata(rdata), .src_a(src_a),
      .src_b(src_b), .src_c(src_c), .periph_irq_req(periph_irq_req),
      .irq(irq));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Strobe stays up until the next request or idle, so no double drive
   task automatic wr(logic [3:0] ad, logic [7:0] wd);
      bus <= '{ad, wd, 1'b1, 1'b0};
      @(posedge clock);
   endtask
   task automatic rchk(logic [3:0] ad, logic [7:0] exp);
      bus <= '{ad, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 chk(rdata, exp);
      @(posedge clock);
   endtask
   task automatic lvl(logic req, logic irq_exp);
      bus <= '0;
      #1 chk({7'h00, periph_irq_req}, {7'h00, req});
      chk({7'h00, irq}, {7'h00, irq_exp});
      @(posedge clock);
   endtask
   // The write lands in the same cycle as the peripheral pulse
   task automatic evt(logic [23:0] pat, logic [3:0] ad, logic [7:0] wd);
      fire <= 1'b1;
      ev <= pat;
      @(posedge clock);
      fire <= 1'b0;
      wr(ad, wd);
      bus <= '0;
      @(posedge clock);
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      for (int j = 0; j < 4; j++) rchk(4'(j), 8'h00);
      for (int i = 0; i < 32; i++) begin
         lf = lfsr(lf);
         p = i < 24 ? 24'h000001 << i : lf[23:0];
         a = {2'b00, lf[1:0]};
         d = i < 24 ? 8'h00 : lf[31:24];
         evt(p, a, d);
         if (a < 4'h3) fm[a] = fm[a] & ~wm[a] | d & wm[a];
         fm[0] |= p[23:16];
         fm[1] |= p[15:8] & pifb_pkg::IMPL_B;
         fm[2] |= p[7:0];
         for (int j = 0; j < 3; j++) rchk(4'(j), fm[j][7:0]);
      end
      wr(pifb_pkg::OFS_FLAGS_A, 8'h00);
      rchk(pifb_pkg::OFS_FLAGS_A, 8'h30);
      wr(pifb_pkg::OFS_FLAGS_B, 8'hff);
      rchk(pifb_pkg::OFS_FLAGS_B, 8'hef);
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      rchk(pifb_pkg::OFS_FLAGS_A, 8'h00);
      wr(pifb_pkg::OFS_EN_A, 8'h01);
      wr(pifb_pkg::OFS_CORE_CTL, 8'hc0);
      wr(pifb_pkg::OFS_IRQ_MASK, 8'h01);
      lvl(1'b0, 1'b0);
      evt(24'h010000, 4'h3, 8'h00);
      lvl(1'b1, 1'b1);
      rchk(pifb_pkg::OFS_IRQ_STAT, 8'h09);
      lvl(1'b1, 1'b0);
      wr(pifb_pkg::OFS_CORE_CTL, 8'h80);
      lvl(1'b0, 1'b0);
      wr(pifb_pkg::OFS_CORE_CTL, 8'hc0);
      lvl(1'b1, 1'b0);
      wr(pifb_pkg::OFS_EN_A, 8'h00);
      lvl(1'b0, 1'b0);
      clk_en <= 1'b0;
      evt(24'h0000ff, pifb_pkg::OFS_FLAGS_A, 8'hff);
      clk_en <= 1'b1;
      rchk(pifb_pkg::OFS_FLAGS_C, 8'h00);
      rchk(pifb_pkg::OFS_FLAGS_A, 8'h01);
      tally_and_finish();
   end
endmodule
